// File: rtl/aoc_control.sv
`default_nettype none
// Function
// RL1: aux mode drives alu function select from our select outputs
// RL2: select comes from microword bits or from condition decode logic
// RL3: four select pins carry two logical signals, each twice
// RL4: aux mode subtraction asserts carry-in to correct a minus b minus one
// RL5: code decoder gives active-low outputs for codes 1,2,5,6,7
// RL6: on command inhibit status word clock except condition codes
// RL7: pointer bit 8 output enables extended and floating logic
// RL8: duplicate pointer-bit-8 enable copies share electrical load
// RL9: supply branch code bit 8 as data for host pointer bit 8
// RL10: drive carry-out mux select to pick alu bit 15, two pins
// RL11: while option active supply the bus-request flag clock
// RL12: flag clock made on each count-equals-zero branch test
// RL13: pulses one and two merge into data register and counter clock
// RL14: overflow flag clocked on its enable with pulse one or two
// RL15: buffer register clocked on its enable with pulse one or three
// RL16: code decoder input is a three-bit microword field
// RL17: counter clock suppressed once count reaches zero
// RL18: gated clocks are synchronous enables qualified by pulse strobes
module aoc_control
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // host timing pulses
   input  wire logic                     timing_pulse_one,
   input  wire logic                     timing_pulse_two,
   input  wire logic                     timing_pulse_three,
   // microword fields
   input  wire logic [aoc_pkg::GPC_W-1:0] general_purpose_code,
   input  wire logic                     uw_aux_alu_mode,
   input  wire logic                     uw_aux_from_cond,
   input  wire logic [1:0]               uw_alu_function,
   input  wire logic                     uw_inhibit_status,
   input  wire logic                     uw_count_zero_test,
   input  wire logic                     uw_overflow_enable,
   input  wire logic                     uw_buffer_enable,
   input  wire logic                     uw_count_enable,
   input  wire logic                     uw_carry_out_sel,
   input  wire logic                     uw_branch_bit_eight,
   // run-time conditions and state
   input  wire logic                     cond_subtract,
   input  wire logic                     cond_add,
   input  wire logic                     option_active,
   input  wire logic [aoc_pkg::CNT_W-1:0] count_value,
   // alu control outputs
   output logic [aoc_pkg::SEL_W-1:0]     aux_alu_function_select,
   output logic                          aux_alu_carry_in,
   output logic [1:0]                    carry_out_mux_select_n,
   // decoder and status
   output logic [aoc_pkg::NUM_GPC-1:0]   gpc_decode_n,
   output logic                          status_word_clock_inhibit_n,
   // pointer bit 8
   output logic                          option_enable_pointer_bit_n,
   output logic                          option_enable_pointer_bit_copy_n,
   output logic                          option_enable_pointer_bit_high,
   output logic                          branch_code_bit_eight_n,
   // gated clock enables
   output logic                          bus_request_flag_clock_n,
   output logic                          combined_pulse_clock,
   output logic                          overflow_flag_clock,
   output logic                          buffer_register_clock,
   output logic                          counter_clock
);
   // ============================================================
   // strobe merge
   aoc_strobe_if strobes ();
   assign strobes.p1 = timing_pulse_one;
   assign strobes.p2 = timing_pulse_two;
   assign strobes.p3 = timing_pulse_three;
   aoc_pulse_merge u_merge
   (
      .s (strobes)
   );

   // ============================================================
   // helpers
   function automatic logic gpc_hit(input logic [aoc_pkg::GPC_W-1:0] code,
                                    input logic [aoc_pkg::GPC_W-1:0] val);
      gpc_hit = (code == val);
   endfunction

   function automatic logic count_is_zero
      (input logic [aoc_pkg::CNT_W-1:0] c);
      count_is_zero = (c[aoc_pkg::ZERO_W-1:0] == aoc_pkg::ZERO_CNT);
   endfunction

   localparam logic [2:0] GPC_LIST [aoc_pkg::NUM_GPC] = '{
      aoc_pkg::GPC_ONE, aoc_pkg::GPC_TWO, aoc_pkg::GPC_FIVE,
      aoc_pkg::GPC_SIX, aoc_pkg::GPC_SEVEN};

   // ============================================================
   // option run state: tracks when the option owns the flow
   aoc_pkg::aoc_state_e state;
   aoc_pkg::aoc_state_e next_state;

   always_comb
   begin
      next_state = state;
      unique case (state)
         aoc_pkg::AOC_IDLE:
            if (option_active)
               next_state = aoc_pkg::AOC_RUN;
         aoc_pkg::AOC_RUN:
            if (!option_active)
               next_state = aoc_pkg::AOC_IDLE;
            else if (uw_count_zero_test && count_is_zero(count_value))
               next_state = aoc_pkg::AOC_HOLD;
         // hold only marks a spent count; outputs treat it as run
         aoc_pkg::AOC_HOLD:
            if (!option_active)
               next_state = aoc_pkg::AOC_IDLE;
            else if (!count_is_zero(count_value))
               next_state = aoc_pkg::AOC_RUN;
         // unused code recovers to idle
         default:
            next_state = aoc_pkg::AOC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         state <= aoc_pkg::AOC_IDLE;
      else if (ce)
         state <= next_state;
   end

   logic active;
   assign active = (state != aoc_pkg::AOC_IDLE);

   // ============================================================
   // alu control
   logic [1:0] next_func;
   logic       next_cin;

   always_comb
   begin
      next_func = uw_alu_function; // RL2
      if (uw_aux_from_cond) // RL2
      begin
         if (cond_subtract)
            next_func = aoc_pkg::ALU_SUB;
         else if (cond_add)
            next_func = aoc_pkg::ALU_ADD;
         else
            next_func = aoc_pkg::ALU_PASS;
      end
      // corrects a-b-1 into a true difference
      next_cin = uw_aux_alu_mode && (next_func == aoc_pkg::ALU_SUB); // RL4
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         aux_alu_function_select <= '0;
      else if (ce)
      begin
         if (uw_aux_alu_mode) // RL1
            // two logical lines, each on two pins
            aux_alu_function_select <= {next_func, next_func}; // RL3
         else
            aux_alu_function_select <= '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         aux_alu_carry_in <= 1'h0;
      else if (ce)
         aux_alu_carry_in <= next_cin; // RL4
   end

   // low selects alu bit 15 as carry-out; both pins share one term
   always_ff @(posedge clk)
   begin
      if (rst)
         carry_out_mux_select_n <= '1;
      else if (ce)
         carry_out_mux_select_n <= {2{~uw_carry_out_sel}}; // RL10
   end

   // ============================================================
   // code decoder
   // one compare per decoded code; outputs idle high
   logic [aoc_pkg::NUM_GPC-1:0] gpc_match;

   for (genvar g = 0; g < aoc_pkg::NUM_GPC; g++)
   begin : g_gpc
      assign gpc_match[g] =
         gpc_hit(general_purpose_code, GPC_LIST[g]); // RL16
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         gpc_decode_n <= '1;
      else if (ce)
         gpc_decode_n <= ~gpc_match; // RL5
   end

   // ============================================================
   // status word clock inhibit
   always_ff @(posedge clk)
   begin
      if (rst)
         status_word_clock_inhibit_n <= 1'h1;
      else if (ce)
         // condition code bits stay clocked regardless
         status_word_clock_inhibit_n <= ~uw_inhibit_status; // RL6
   end

   // ============================================================
   // pointer bit 8
   always_ff @(posedge clk)
   begin
      if (rst)
         option_enable_pointer_bit_n <= 1'h1;
      else if (ce)
         option_enable_pointer_bit_n <= ~option_active; // RL7
   end

   // separate flops so each pin carries its own load
   always_ff @(posedge clk)
   begin
      if (rst)
         option_enable_pointer_bit_copy_n <= 1'h1;
      else if (ce)
         option_enable_pointer_bit_copy_n <= ~option_active; // RL8
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         option_enable_pointer_bit_high <= 1'h0;
      else if (ce)
         option_enable_pointer_bit_high <= option_active; // RL8
   end

   // host loads its pointer bit 8 from this on its own pointer clock
   always_ff @(posedge clk)
   begin
      if (rst)
         branch_code_bit_eight_n <= 1'h1;
      else if (ce)
         branch_code_bit_eight_n <= ~uw_branch_bit_eight; // RL9
   end

   // ============================================================
   // gated clocks as one-cycle enables, not derived clocks
   // derived clocks would skew against the host; enables keep one domain
   logic cnt_zero;
   logic pulse_one_two;
   logic pulse_one_three;
   assign cnt_zero        = count_is_zero(count_value);
   assign pulse_one_two   = strobes.p12;
   assign pulse_one_three = strobes.p13;

   // long loops test zero often, giving the host dma a window
   always_ff @(posedge clk)
   begin
      if (rst)
         bus_request_flag_clock_n <= 1'h1;
      else if (ce)
         bus_request_flag_clock_n <=
            ~(active && uw_count_zero_test && pulse_one_two); // RL11 RL12
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         combined_pulse_clock <= 1'h0;
      else if (ce)
         combined_pulse_clock <= pulse_one_two; // RL13 RL18
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         overflow_flag_clock <= 1'h0;
      else if (ce)
         overflow_flag_clock <= uw_overflow_enable && pulse_one_two; // RL14
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         buffer_register_clock <= 1'h0;
      else if (ce)
         buffer_register_clock <= uw_buffer_enable && pulse_one_three; // RL15
   end

   // no count past zero, whether or not a zero test is pending
   always_ff @(posedge clk)
   begin
      if (rst)
         counter_clock <= 1'h0;
      else if (ce)
         counter_clock <=
            uw_count_enable && pulse_one_two && !cnt_zero; // RL17 RL18
   end
endmodule
`default_nettype wire

// File: rtl/aoc_pkg.sv
`default_nettype none
package aoc_pkg;
   // general purpose code values with decoded outputs
   localparam logic [2:0] GPC_ONE   = 3'h1;
   localparam logic [2:0] GPC_TWO   = 3'h2;
   localparam logic [2:0] GPC_FIVE  = 3'h5;
   localparam logic [2:0] GPC_SIX   = 3'h6;
   localparam logic [2:0] GPC_SEVEN = 3'h7;
   localparam int         GPC_W     = 3;
   localparam int         SEL_W     = 4;
   localparam int         CNT_W     = 8;
   // count bits compared for the zero test
   localparam int         ZERO_W    = 6;
   localparam logic [5:0] ZERO_CNT  = 6'h00;
   // aux alu codes: subtract (a-b-1), add and pass
   localparam logic [1:0] ALU_SUB   = 2'h1;
   localparam logic [1:0] ALU_ADD   = 2'h2;
   localparam logic [1:0] ALU_PASS  = 2'h0;
   localparam int         NUM_GPC   = 5;
   typedef enum logic [1:0] {
      AOC_IDLE = 2'b00,
      AOC_RUN  = 2'b01,
      AOC_HOLD = 2'b11
   } aoc_state_e;
endpackage
`default_nettype wire

// File: rtl/aoc_if.sv
`default_nettype none
interface aoc_strobe_if;
   logic p1;
   logic p2;
   logic p3;
   logic p12;
   logic p13;
   modport src (input p1, input p2, input p3, output p12, output p13);
   modport dst (input p12, input p13);
endinterface
`default_nettype wire

// File: rtl/aoc_pulse_merge.sv
`default_nettype none
module aoc_pulse_merge
(
   aoc_strobe_if.src s
);
   // pulses are strobes in the clk domain, not clocks
   assign s.p12 = s.p1 | s.p2; // RL13
   assign s.p13 = s.p1 | s.p3;
endmodule
`default_nettype wire

// File: dv/aoc_host_model.sv
`default_nettype none
module aoc_host_model
(
   // clock and run
   input  wire logic clk,
   input  wire logic run,
   // timing strobes
   output logic      p1,
   output logic      p2,
   output logic      p3
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph = 2'h0;
   // moves on the falling edge, off the sampling edge
   always @(negedge clk) ph <= run ? ph + 2'h1 : 2'h0;
   assign p1 = ph == 2'h1;
   assign p2 = ph == 2'h2;
   assign p3 = ph == 2'h3;
endmodule
`default_nettype wire

// File: dv/aoc_control_assertions.sv
`default_nettype none
module aoc_control_assertions
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ce,
   // inputs
   input wire logic       timing_pulse_one,
   input wire logic       timing_pulse_two,
   input wire logic       timing_pulse_three,
   input wire logic       uw_aux_alu_mode,
   input wire logic       uw_count_zero_test,
   input wire logic       uw_buffer_enable,
   input wire logic       uw_carry_out_sel,
   input wire logic [7:0] count_value,
   // outputs
   input wire logic [3:0] aux_alu_function_select,
   input wire logic       aux_alu_carry_in,
   input wire logic [1:0] carry_out_mux_select_n,
   input wire logic       combined_pulse_clock,
   input wire logic       buffer_register_clock,
   input wire logic       counter_clock,
   input wire logic       bus_request_flag_clock_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // guard: last edge was a live sampling edge
   logic ok;
   always_ff @(posedge clk) ok <= ce && !rst;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_SEL_PAIR: assert property (
      aux_alu_function_select[3:2] == aux_alu_function_select[1:0])
      else $error("select halves differ");
   AST_SEL_OFF: assert property (
      ok && !$past(uw_aux_alu_mode) |-> aux_alu_function_select == 4'h0)
      else $error("select driven outside aux mode");
   AST_CIN: assert property (
      ok && aux_alu_carry_in |-> $past(uw_aux_alu_mode))
      else $error("carry in outside aux mode");
   AST_COMUX: assert property (
      ok |-> carry_out_mux_select_n == {2{!$past(uw_carry_out_sel)}})
      else $error("carry out select wrong");
   AST_COMB: assert property (
      ok |-> combined_pulse_clock ==
      ($past(timing_pulse_one) || $past(timing_pulse_two)))
      else $error("combined pulse wrong");
   AST_BUF: assert property (
      ok |-> buffer_register_clock == ($past(uw_buffer_enable) &&
      ($past(timing_pulse_one) || $past(timing_pulse_three))))
      else $error("buffer clock wrong");
   AST_CNT: assert property (
      ok && counter_clock |-> $past(count_value[5:0]) != 6'h00)
      else $error("counter clocked at zero");
   AST_BUS: assert property (
      ok && !bus_request_flag_clock_n |-> $past(uw_count_zero_test) &&
      ($past(timing_pulse_one) || $past(timing_pulse_two)))
      else $error("flag clock without zero test");
   cover property (!bus_request_flag_clock_n);
   cover property (counter_clock);
   cover property (aux_alu_carry_in);
endmodule
bind aoc_control aoc_control_assertions u_chk (.*);
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [21:0] rst_out = 22'h01ffb0;
   localparam logic [2:0] gv [5] = '{aoc_pkg::GPC_ONE, aoc_pkg::GPC_TWO,
      aoc_pkg::GPC_FIVE, aoc_pkg::GPC_SIX, aoc_pkg::GPC_SEVEN};
   logic clk = 0, rst = 1, ce = 1, run = 0, act = 0;
   logic aux = 0, cf = 0, cs = 0, ca = 0, inh = 0, zt = 0, oa = 0;
   logic oe = 0, be = 0, cne = 0, cos = 0, bb = 0, p1, p2, p3;
   logic [2:0] code = 3'h0;
   logic [1:0] fn = 2'h0;
   logic [7:0] cnt = 8'h00;
   wire logic [21:0] o;
   int n_checks = 0, n_mismatch = 0, cyc = 0;
   always #5 clk = ~clk;
   aoc_host_model u_host (.clk(clk), .run(run), .p1(p1), .p2(p2), .p3(p3));
   aoc_control dut (.clk(clk), .rst(rst), .ce(ce),
      .timing_pulse_one(p1), .timing_pulse_two(p2), .timing_pulse_three(p3),
      .general_purpose_code(code), .uw_aux_alu_mode(aux),
      .uw_aux_from_cond(cf), .uw_alu_function(fn),
      .uw_inhibit_status(inh), .uw_count_zero_test(zt),
      .uw_overflow_enable(oe), .uw_buffer_enable(be),
      .uw_count_enable(cne), .uw_carry_out_sel(cos),
      .uw_branch_bit_eight(bb), .cond_subtract(cs), .cond_add(ca),
      .option_active(oa), .count_value(cnt),
      .aux_alu_function_select(o[21:18]), .aux_alu_carry_in(o[17]),
      .carry_out_mux_select_n(o[16:15]), .gpc_decode_n(o[14:10]),
      .status_word_clock_inhibit_n(o[9]),
      .option_enable_pointer_bit_n(o[8]),
      .option_enable_pointer_bit_copy_n(o[7]),
      .option_enable_pointer_bit_high(o[6]),
      .branch_code_bit_eight_n(o[5]), .bus_request_flag_clock_n(o[4]),
      .combined_pulse_clock(o[3]), .overflow_flag_clock(o[2]),
      .buffer_register_clock(o[1]), .counter_clock(o[0]));
   // ==========
   task automatic chk(string n, logic [21:0] x, logic [21:0] y);
      n_checks++;
      if (y !== x)
      begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", n, x, y);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // one cycle: expectation from inputs, compare after the edge
   task automatic step();
      logic [21:0] e;
      logic [1:0] f;
      #1;
      f = !cf ? fn : cs ? aoc_pkg::ALU_SUB : ca ? aoc_pkg::ALU_ADD
         : aoc_pkg::ALU_PASS;
      e[21:17] = aux ? {f, f, f == aoc_pkg::ALU_SUB} : 5'h00;
      e[16:15] = {2{!cos}};
      foreach (gv[k]) e[10+k] = code != gv[k];
      e[9:4] = {!inh, !oa, !oa, oa, !bb, !(act && zt && (p1 || p2))};
      e[3:0] = {p1 || p2, oe && (p1 || p2), be && (p1 || p3),
         cne && (p1 || p2) && cnt[5:0] != 6'h00};
      // frozen dut keeps its state, so the model must too
      if (rst)
      begin
         e = rst_out;
         act = 1'h0;
      end
      else if (ce)
         act = oa;
      else
         e = o;
      @(negedge clk);
      chk("select", e[21:18], o[21:18]);
      chk("carry_in", e[17], o[17]);
      chk("co_mux", e[16:15], o[16:15]);
      chk("gpc", e[14:10], o[14:10]);
      chk("inhibit", e[9], o[9]);
      chk("ptr_en", e[8:6], o[8:6]);
      chk("branch8", e[5], o[5]);
      chk("bus_clk", e[4], o[4]);
      chk("pulse_clk", e[3], o[3]);
      chk("ovf_clk", e[2], o[2]);
      chk("buf_clk", e[1], o[1]);
      chk("cnt_clk", e[0], o[0]);
   endtask
   // ==========
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   initial
   begin
      repeat (3) @(negedge clk);
      chk("reset", rst_out, o);
      $display("reset test done");
      run = 1;
      for (int i = 0; i < 128; i++)
      begin
         code = i[2:0];
         fn = i[4:3];
         {aux, cf, cs, ca} = {i[3] | i[6], i[4], i[5], i[1]};
         {inh, zt, oe, be} = {i[0], i[1] | i[6], i[2], ~i[0]};
         {cne, cos, bb} = {i[5] ^ i[2], i[3], i[6] ^ i[1]};
         oa = i[5] | (i[6] & i[0]);
         cnt = i[2] ? {i[1:0], 6'h00} : 8'(i);
         ce = i[2:0] != 3'h5;
         rst = i == 100;
         step();
      end
      $display("vector test done");
      end_sim();
   end
endmodule
`default_nettype wire
